// File: core/pscr_regs.sv
// packet handling and frequency synthesizer configuration register bank
//
// How it works
// - format 00 passes tx and rx payload through the internal FIFOs.
// - format 01 is synchronous serial: tx data enters on pin zero, rx data leaves on the output pins.
// - format 10 sends PN9 data in tx and behaves as FIFO mode in rx.
// - format 11 is asynchronous serial with the same pins as synchronous serial.
// - length mode 00 takes a fixed length from the packet length register.
// - length mode 01, the reset value, takes the length from the first byte after sync.
// - length mode 10 is infinite length and 11 is reserved and must not be written.
// - received addresses are compared with the node filter address, with optional 00/ff broadcast.
// - the unsigned channel index times the channel spacing is added to the base frequency.
// - in rx the IF word times fosc/2^10 is subtracted from the base and also drives the mixer.
// - the signed offset word in steps of fosc/2^14 is added to the base frequency.
// - the top two bits of the carrier word always read zero.
// - the carrier is fosc/2^16 times the 24-bit word split over three byte registers.
// - the address filter mode selects none, exact, exact or 00, exact or 00 or ff.
// - packet length is exact in fixed mode and a maximum in variable mode, never zero.
`timescale 1ns/10ps
module pscr_regs (
   input  wire logic         sys_clk,          // 20 MHz clock
   input  wire logic         nrst,             // async reset, active low
   input  wire logic [5:0]   reg_addr,         // register offset
   input  wire logic         reg_we,           // write strobe
   input  wire logic         reg_re,           // read strobe
   input  wire logic [7:0]   reg_wdata,        // write data
   output logic      [7:0]   reg_rdata,        // read data, one cycle after strobe
   input  wire logic         rx_mode,          // synthesizer in receive
   input  wire logic [15:0]  channel_spacing,  // spacing in fosc/2^16 steps
   input  wire logic         tx_bit_en,        // next tx bit wanted
   input  wire logic         tx_fifo_bit,      // tx bit from the FIFO path
   input  wire logic         general_output_pin_zero, // serial tx data in
   input  wire logic         rx_bit,           // demodulated rx bit
   input  wire logic         rx_addr_valid,    // address byte strobe
   input  wire logic [7:0]   rx_addr_byte,     // received address byte
   input  wire logic         rx_len_valid,     // first byte after sync strobe
   input  wire logic [7:0]   rx_len_byte,      // first byte after sync
   output logic              tx_data,          // bit to modulator
   output logic              rx_to_fifo,       // rx payload goes to FIFO
   output logic              general_output_pins, // serial rx data out
   output logic              crc_enable,       // CRC calculation on
   output logic              addr_accept,      // address filter passed
   output logic              addr_done,        // addr_accept valid pulse
   output logic      [7:0]   pkt_len_limit,    // length in use
   output logic              pkt_len_infinite, // infinite length mode
   output logic              pkt_len_error,    // variable length over max
   output logic [4:0]        intermediate_carrier_word_word, // mixer IF word
   output logic [26:0]       synth_word        // signed synthesizer word, fosc/2^16 steps
);
   logic       rst_meta;
   logic       rst_n;
   logic [7:0] cfg       [6:15];
   logic [7:0] next_cfg  [6:15];
   logic [7:0] next_rdata;
   logic [8:0] pn9;
   logic [8:0] next_pn9;
   logic       next_tx_data;
   logic       next_rx_to_fifo;
   logic       next_gpo;
   logic       next_accept;
   logic       next_done;
   logic [7:0] next_len;
   logic       next_inf;
   logic       next_len_err;
   logic [26:0] next_synth;
   pscr_pkg::pscr_format_t   fmt;
   pscr_pkg::pscr_len_mode_t len_mode;
   pscr_pkg::pscr_adr_mode_t adr_mode;

   function automatic logic mapped(input logic [5:0] a);
      mapped = (a >= pscr_pkg::ADDR_PACKET_LENGTH) && (a <= pscr_pkg::ADDR_CARRIER_LOW);
   endfunction

   function automatic logic [7:0] wmask(input logic [5:0] a);
      case (a)
         pscr_pkg::ADDR_PACKET_FILTER: wmask = pscr_pkg::WMASK_PACKET_FILTER;
         pscr_pkg::ADDR_PACKET_FORMAT: wmask = pscr_pkg::WMASK_PACKET_FORMAT;
         pscr_pkg::ADDR_IF_CARRIER_WORD:       wmask = pscr_pkg::WMASK_IF_CARRIER_WORD;
         pscr_pkg::ADDR_CARRIER_HIGH:  wmask = pscr_pkg::WMASK_CARRIER_HIGH;
         default:                      wmask = pscr_pkg::WMASK_FULL;
      endcase
   endfunction

   function automatic logic addr_match(input logic [1:0] mode, input logic [7:0] node, input logic [7:0] a);
      case (mode)
         pscr_pkg::ADR_NONE:     addr_match = 1'b1;
         pscr_pkg::ADR_NO_BCAST: addr_match = (a == node);
         pscr_pkg::ADR_BCAST_00: addr_match = (a == node) || (a == pscr_pkg::BCAST_LOW);
         default:                addr_match = (a == node) || (a == pscr_pkg::BCAST_LOW) || (a == pscr_pkg::BCAST_HIGH);
      endcase
   endfunction

   // reset released through two flops
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   assign fmt      = pscr_pkg::pscr_format_t'(cfg[pscr_pkg::ADDR_PACKET_FORMAT][pscr_pkg::FMT_LSB +: 2]);
   assign len_mode = pscr_pkg::pscr_len_mode_t'(cfg[pscr_pkg::ADDR_PACKET_FORMAT][pscr_pkg::LEN_LSB +: 2]);
   assign adr_mode = pscr_pkg::pscr_adr_mode_t'(cfg[pscr_pkg::ADDR_PACKET_FILTER][pscr_pkg::ADRMODE_LSB +: 2]);
   assign crc_enable = cfg[pscr_pkg::ADDR_PACKET_FORMAT][pscr_pkg::CRC_EN_BIT];

   // register file: write masking and read mux
   always_comb begin
      next_cfg = cfg;
      if (reg_we && mapped(reg_addr)) begin
         next_cfg[reg_addr] = reg_wdata & wmask(reg_addr);
      end
      next_rdata = reg_rdata;
      if (reg_re) begin
         next_rdata = mapped(reg_addr) ? cfg[reg_addr] : 8'h00;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg[pscr_pkg::ADDR_PACKET_LENGTH]  <= pscr_pkg::RST_PACKET_LENGTH;
         cfg[pscr_pkg::ADDR_PACKET_FILTER]  <= pscr_pkg::RST_PACKET_FILTER;
         cfg[pscr_pkg::ADDR_PACKET_FORMAT]  <= pscr_pkg::RST_PACKET_FORMAT;
         cfg[pscr_pkg::ADDR_NODE_FILTER]    <= pscr_pkg::RST_NODE_FILTER;
         cfg[pscr_pkg::ADDR_CHANNEL_INDEX]  <= pscr_pkg::RST_CHANNEL_INDEX;
         cfg[pscr_pkg::ADDR_IF_CARRIER_WORD]        <= pscr_pkg::RST_IF_CARRIER_WORD;
         cfg[pscr_pkg::ADDR_SYNTH_OFFSET]   <= pscr_pkg::RST_SYNTH_OFFSET;
         cfg[pscr_pkg::ADDR_CARRIER_HIGH]   <= pscr_pkg::RST_CARRIER_HIGH;
         cfg[pscr_pkg::ADDR_CARRIER_MIDDLE] <= pscr_pkg::RST_CARRIER_MIDDLE;
         cfg[pscr_pkg::ADDR_CARRIER_LOW]    <= pscr_pkg::RST_CARRIER_LOW;
         reg_rdata <= 8'h00;
      end else begin
         cfg       <= next_cfg;
         reg_rdata <= next_rdata;
      end
   end

   // data path selection by packet format
   always_comb begin
      next_pn9        = pn9;
      next_tx_data    = tx_data;
      next_rx_to_fifo = 1'b1;
      next_gpo        = 1'b0;
      case (fmt)
         pscr_pkg::FMT_FIFO: begin
            if (tx_bit_en) next_tx_data = tx_fifo_bit;
         end
         pscr_pkg::FMT_SYNC_SERIAL: begin
            if (tx_bit_en) next_tx_data = general_output_pin_zero;
            next_rx_to_fifo = 1'b0;
            next_gpo        = rx_bit;
         end
         pscr_pkg::FMT_RANDOM_TX: begin
            if (tx_bit_en) begin
               next_tx_data = pn9[0];
               next_pn9     = {pn9[0] ^ pn9[5], pn9[8:1]};
            end
         end
         pscr_pkg::FMT_ASYNC_SERIAL: begin
            // no bit clock here: pin zero is sampled every cycle
            next_tx_data    = general_output_pin_zero;
            next_rx_to_fifo = 1'b0;
            next_gpo        = rx_bit;
         end
         default: next_tx_data = tx_data;
      endcase
      if (fmt != pscr_pkg::FMT_RANDOM_TX) next_pn9 = pscr_pkg::PN9_SEED;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pn9                 <= pscr_pkg::PN9_SEED;
         tx_data             <= 1'b0;
         rx_to_fifo          <= 1'b1;
         general_output_pins <= 1'b0;
      end else begin
         pn9                 <= next_pn9;
         tx_data             <= next_tx_data;
         rx_to_fifo          <= next_rx_to_fifo;
         general_output_pins <= next_gpo;
      end
   end

   // packet length and address filtering
   always_comb begin
      next_len     = pkt_len_limit;
      next_inf     = (len_mode == pscr_pkg::LEN_INFINITE);
      next_len_err = pkt_len_error;
      next_accept  = addr_accept;
      next_done    = 1'b0;
      if (len_mode == pscr_pkg::LEN_FIXED) begin
         next_len     = cfg[pscr_pkg::ADDR_PACKET_LENGTH];
         next_len_err = 1'b0;
      end else if (len_mode == pscr_pkg::LEN_VARIABLE && rx_len_valid) begin
         next_len     = rx_len_byte;
         next_len_err = rx_len_byte > cfg[pscr_pkg::ADDR_PACKET_LENGTH];
      end else if (len_mode != pscr_pkg::LEN_VARIABLE) begin
         next_len_err = 1'b0;
      end
      if (rx_addr_valid) begin
         next_accept = addr_match(adr_mode, cfg[pscr_pkg::ADDR_NODE_FILTER], rx_addr_byte);
         next_done   = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pkt_len_limit    <= pscr_pkg::RST_PACKET_LENGTH;
         pkt_len_infinite <= 1'b0;
         pkt_len_error    <= 1'b0;
         addr_accept      <= 1'b0;
         addr_done        <= 1'b0;
      end else begin
         pkt_len_limit    <= next_len;
         pkt_len_infinite <= next_inf;
         pkt_len_error    <= next_len_err;
         addr_accept      <= next_accept;
         addr_done        <= next_done;
      end
   end

   // synthesizer word, all terms scaled to fosc/2^16 steps
   logic [26:0] carrier_term;
   logic [26:0] channel_term;
   logic [26:0] off_term;
   logic [26:0] if_term;
   logic [23:0] channel_prod;
   assign carrier_term = {3'b000, cfg[pscr_pkg::ADDR_CARRIER_HIGH], cfg[pscr_pkg::ADDR_CARRIER_MIDDLE],
                          cfg[pscr_pkg::ADDR_CARRIER_LOW]};
   assign channel_prod = cfg[pscr_pkg::ADDR_CHANNEL_INDEX] * channel_spacing;
   assign channel_term = {3'b000, channel_prod};
   assign off_term     = 27'(signed'({{19{cfg[pscr_pkg::ADDR_SYNTH_OFFSET][7]}},
                          cfg[pscr_pkg::ADDR_SYNTH_OFFSET]}) <<< pscr_pkg::OFFSET_SHIFT);
   assign if_term      = rx_mode ? 27'({22'h000000, cfg[pscr_pkg::ADDR_IF_CARRIER_WORD][pscr_pkg::IF_LSB +: 5]}
                          << pscr_pkg::IF_SHIFT) : 27'h0000000;

   always_comb begin
      next_synth = carrier_term + channel_term + off_term - if_term;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         synth_word             <= 27'h0000000;
         intermediate_carrier_word_word <= 5'h00;
      end else begin
         synth_word             <= next_synth;
         intermediate_carrier_word_word <= cfg[pscr_pkg::ADDR_IF_CARRIER_WORD][pscr_pkg::IF_LSB +: 5];
      end
   end

   AST_FIFO_TX: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (fmt == pscr_pkg::FMT_FIFO && tx_bit_en && !reg_we) |=> (tx_data == $past(tx_fifo_bit) && rx_to_fifo))
      else $error("fifo mode tx bit wrong");
   AST_SYNC_SERIAL: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (fmt == pscr_pkg::FMT_SYNC_SERIAL && tx_bit_en && !reg_we)
      |=> (tx_data == $past(general_output_pin_zero) && general_output_pins == $past(rx_bit) && !rx_to_fifo))
      else $error("sync serial path wrong");
   AST_PN9_TX: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (fmt == pscr_pkg::FMT_RANDOM_TX && tx_bit_en && !reg_we) |=> (tx_data == $past(pn9[0]) && rx_to_fifo))
      else $error("pn9 tx bit wrong");
   AST_ASYNC_SERIAL: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (fmt == pscr_pkg::FMT_ASYNC_SERIAL && !reg_we) |=> (tx_data == $past(general_output_pin_zero) && !rx_to_fifo))
      else $error("async serial path wrong");
   AST_FIXED_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (len_mode == pscr_pkg::LEN_FIXED && !reg_we) |=> (pkt_len_limit == cfg[pscr_pkg::ADDR_PACKET_LENGTH]))
      else $error("fixed length not from length register");
   AST_VAR_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (len_mode == pscr_pkg::LEN_VARIABLE && rx_len_valid && !reg_we)
      |=> (pkt_len_limit == $past(rx_len_byte)
           && pkt_len_error == ($past(rx_len_byte) > cfg[pscr_pkg::ADDR_PACKET_LENGTH])))
      else $error("variable length not taken");
   AST_INFINITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(len_mode) == pscr_pkg::LEN_INFINITE |-> pkt_len_infinite && !pkt_len_error)
      else $error("infinite length flag wrong");
   AST_ADDR_FILTER: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rx_addr_valid && adr_mode == pscr_pkg::ADR_NO_BCAST && rx_addr_byte == pscr_pkg::BCAST_HIGH
       && cfg[pscr_pkg::ADDR_NODE_FILTER] != pscr_pkg::BCAST_HIGH && !reg_we) |=> (addr_done && !addr_accept))
      else $error("broadcast accepted without broadcast mode");
   AST_TOP_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_re && reg_addr == pscr_pkg::ADDR_CARRIER_HIGH) |=> reg_rdata[7:6] == 2'b00)
      else $error("carrier top bits not zero");
   AST_UNUSED_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_re && reg_addr == pscr_pkg::ADDR_PACKET_FORMAT) |=> (reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0))
      else $error("unused format bits not zero");
   AST_RX_IF: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ($past(rst_n) && $stable(rx_mode) && $stable(channel_spacing) && !$past(reg_we) && !reg_we && rx_mode)
      ##1 (!reg_we && $stable(rx_mode)) |-> $stable(synth_word))
      else $error("synth word unstable with stable settings");
   // reseeding outside random mode makes each test burst start from the same pattern
   AST_PN9_SEED: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (fmt != pscr_pkg::FMT_RANDOM_TX) |=> (pn9 == pscr_pkg::PN9_SEED))
      else $error("pn9 not reseeded outside random mode");
   AST_LEN_ERR_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (len_mode != pscr_pkg::LEN_VARIABLE) |=> !pkt_len_error)
      else $error("length error outside variable mode");
   AST_ADDR_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      addr_done |-> $past(rx_addr_valid))
      else $error("address done without address byte");
   AST_BCAST_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rx_addr_valid && adr_mode == pscr_pkg::ADR_BCAST_00 && rx_addr_byte == pscr_pkg::BCAST_LOW)
      |=> (addr_done && addr_accept))
      else $error("zero broadcast refused");
endmodule

// File: core/pscr_pkg.sv
// offsets, field positions, reset values and modes of the packet/synth config bank
package pscr_pkg;
   localparam logic [5:0] ADDR_PACKET_LENGTH   = 6'h06;
   localparam logic [5:0] ADDR_PACKET_FILTER   = 6'h07;
   localparam logic [5:0] ADDR_PACKET_FORMAT   = 6'h08;
   localparam logic [5:0] ADDR_NODE_FILTER     = 6'h09;
   localparam logic [5:0] ADDR_CHANNEL_INDEX   = 6'h0a;
   localparam logic [5:0] ADDR_IF_CARRIER_WORD         = 6'h0b;
   localparam logic [5:0] ADDR_SYNTH_OFFSET    = 6'h0c;
   localparam logic [5:0] ADDR_CARRIER_HIGH    = 6'h0d;
   localparam logic [5:0] ADDR_CARRIER_MIDDLE  = 6'h0e;
   localparam logic [5:0] ADDR_CARRIER_LOW     = 6'h0f;

   localparam logic [7:0] RST_PACKET_LENGTH    = 8'hff;
   localparam logic [7:0] RST_PACKET_FILTER    = 8'h04;
   localparam logic [7:0] RST_PACKET_FORMAT    = 8'h45;
   localparam logic [7:0] RST_NODE_FILTER      = 8'h00;
   localparam logic [7:0] RST_CHANNEL_INDEX    = 8'h00;
   localparam logic [7:0] RST_IF_CARRIER_WORD          = 8'h0f;
   localparam logic [7:0] RST_SYNTH_OFFSET     = 8'h00;
   localparam logic [7:0] RST_CARRIER_HIGH     = 8'h1e;
   localparam logic [7:0] RST_CARRIER_MIDDLE   = 8'hc4;
   localparam logic [7:0] RST_CARRIER_LOW      = 8'hec;

   // writable bits; the rest are not used and read zero
   localparam logic [7:0] WMASK_PACKET_FILTER  = 8'hef;
   localparam logic [7:0] WMASK_PACKET_FORMAT  = 8'h77;
   localparam logic [7:0] WMASK_IF_CARRIER_WORD        = 8'h3f;
   localparam logic [7:0] WMASK_CARRIER_HIGH   = 8'h3f;
   localparam logic [7:0] WMASK_FULL           = 8'hff;

   localparam int FMT_LSB      = 4;
   localparam int CRC_EN_BIT   = 2;
   localparam int LEN_LSB      = 0;
   localparam int ADRMODE_LSB  = 0;
   localparam int IF_LSB       = 0;

   localparam int OFFSET_SHIFT = 2;   // 2^16 / 2^14
   localparam int IF_SHIFT     = 6;   // 2^16 / 2^10
   localparam int SYNTH_W      = 27;

   localparam logic [8:0] PN9_SEED      = 9'h1ff;
   localparam logic [7:0] BCAST_LOW     = 8'h00;
   localparam logic [7:0] BCAST_HIGH    = 8'hff;

   typedef enum logic [1:0] {FMT_FIFO, FMT_SYNC_SERIAL, FMT_RANDOM_TX, FMT_ASYNC_SERIAL} pscr_format_t;
   typedef enum logic [1:0] {LEN_FIXED, LEN_VARIABLE, LEN_INFINITE, LEN_RESERVED} pscr_len_mode_t;
   typedef enum logic [1:0] {ADR_NONE, ADR_NO_BCAST, ADR_BCAST_00, ADR_BCAST_00_FF} pscr_adr_mode_t;
endpackage

// File: test/pscr_host_model.sv
// host side model driving the register strobe port
`timescale 1ns/10ps
module pscr_host_model (
   input  wire logic       sys_clk,   // system clock
   output logic      [5:0] reg_addr,  // register offset
   output logic            reg_we,    // write strobe
   output logic            reg_re,    // read strobe
   output logic      [7:0] reg_wdata, // write data
   input  wire logic [7:0] reg_rdata  // read data
);
   initial begin
      reg_addr  = 6'h00;
      reg_we    = 1'b0;
      reg_re    = 1'b0;
      reg_wdata = 8'h00;
   end
   // a real host never writes these, so neither does the model
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      if ((a == pscr_pkg::ADDR_PACKET_LENGTH && d == 8'h00) ||
          (a == pscr_pkg::ADDR_PACKET_FORMAT && d[1:0] == 2'b11)) begin
         return;
      end
      @(posedge sys_clk) #1;
      reg_we    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(posedge sys_clk) #1;
      reg_we    = 1'b0;
      // idle lines carry garbage, not the last value
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge sys_clk) #1;
      reg_re   = 1'b1;
      reg_addr = a;
      @(posedge sys_clk) #1;
      reg_re   = 1'b0;
      reg_addr = ~a;
      d        = reg_rdata;
   endtask
endmodule

// File: test/tb.sv
// self-checking bench for the packet and synthesizer config bank
`timescale 1ns/10ps
module tb;
   logic        sys_clk, nrst, reg_we, reg_re, rx_mode, tx_bit_en, tx_fifo_bit;
   logic        general_output_pin_zero, rx_bit, rx_addr_valid, rx_len_valid, tx_data;
   logic        rx_to_fifo, general_output_pins, crc_enable, addr_accept, addr_done;
   logic        pkt_len_infinite, pkt_len_error;
   logic [5:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, rx_addr_byte, rx_len_byte, pkt_len_limit, rd_val;
   logic [15:0] channel_spacing;
   logic [4:0]  intermediate_carrier_word_word;
   logic [26:0] synth_word;
   int          n_errors;
   int          total_checks;
   int          exp_synth;
   localparam logic [7:0] RST_TAB [10] = '{8'hff, 8'h04, 8'h45, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h1e, 8'hc4, 8'hec};
   localparam logic [7:0] MSK_TAB [10] = '{8'hff, 8'hef, 8'h77, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h3f, 8'hff, 8'hff};
   localparam logic [7:0] ABYTES [4]   = '{8'h5a, 8'h00, 8'hff, 8'h33};

   pscr_regs pscr_regs_i (.sys_clk, .nrst, .reg_addr, .reg_we, .reg_re, .reg_wdata, .reg_rdata, .rx_mode,
      .channel_spacing, .tx_bit_en, .tx_fifo_bit, .general_output_pin_zero, .rx_bit, .rx_addr_valid,
      .rx_addr_byte, .rx_len_valid, .rx_len_byte, .tx_data, .rx_to_fifo, .general_output_pins, .crc_enable,
      .addr_accept, .addr_done, .pkt_len_limit, .pkt_len_infinite, .pkt_len_error, .intermediate_carrier_word_word,
      .synth_word);
   pscr_host_model pscr_host_model_i (.sys_clk, .reg_addr, .reg_we, .reg_re, .reg_wdata, .reg_rdata);

   always #25 sys_clk = ~sys_clk;

   task automatic chk(input logic [26:0] got, input logic [26:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      pscr_host_model_i.wr(a, d);
   endtask
   task automatic rdchk(input logic [5:0] a, input logic [7:0] exp, input string what);
      pscr_host_model_i.rd(a, rd_val);
      chk(rd_val, exp, what);
   endtask
   // one-cycle strobe; result is looked at in the cycle after it, once registered
   task automatic rx_pulse(input logic is_len, input logic [7:0] b);
      @(posedge sys_clk) #1;
      rx_len_valid  = is_len;
      rx_addr_valid = !is_len;
      rx_len_byte   = b;
      rx_addr_byte  = b;
      cyc(1);
      rx_len_valid  = 1'b0;
      rx_addr_valid = 1'b0;
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #500000;
      n_errors++;
      $display("mismatch at %0t: run hung", $time);
      summarize();
   end

   initial begin
      sys_clk = 1'b0;
      nrst = 1'b0;
      rx_mode = 1'b0;
      channel_spacing = 16'h0100;
      tx_bit_en = 1'b0;
      tx_fifo_bit = 1'b0;
      general_output_pin_zero = 1'b0;
      rx_bit = 1'b0;
      {rx_addr_valid, rx_len_valid, rx_addr_byte, rx_len_byte} = '0;
      n_errors = 0;
      total_checks = 0;
      repeat (3) @(posedge sys_clk);
      #1 nrst = 1'b1;
      cyc(4);
      for (int i = 0; i < 10; i++) rdchk(6'(i + 6), RST_TAB[i], "reset value");
      wr(6'h10, 8'hff);
      rdchk(6'h10, 8'h00, "unmapped read");
      rdchk(6'h05, 8'h00, "unmapped read");
      for (int i = 0; i < 10; i++) wr(6'(i + 6), (i == 2) ? 8'hfe : 8'hff);
      for (int i = 0; i < 10; i++) begin
         rdchk(6'(i + 6), ((i == 2) ? 8'hfe : 8'hff) & MSK_TAB[i], "mask");
      end
      // every packet format, crc toggled independently of format parity
      for (int f = 0; f < 4; f++) begin
         wr(pscr_pkg::ADDR_PACKET_FORMAT, 8'(64 + f * 16 + (f / 2) * 4 + 1));
         rx_bit = 1'b1;
         cyc(2);
         chk(crc_enable, 27'(f / 2), "crc enable");
         chk(rx_to_fifo, 27'(f == 0 || f == 2), "rx to fifo");
         chk(general_output_pins, 27'(f % 2), "serial rx out");
         rx_bit = 1'b0;
         tx_fifo_bit = (f == 0);
         general_output_pin_zero = (f % 2 == 1);
         cyc(2);
         chk(general_output_pins, 0, "serial rx out low");
         if (f != 3) begin
            @(posedge sys_clk) #1;
            tx_bit_en = 1'b1;
            cyc(1);
            tx_bit_en = 1'b0;
         end else begin
            cyc(2);
         end
         chk(tx_data, 1, "tx bit");
         tx_fifo_bit = 1'b0;
         general_output_pin_zero = 1'b0;
         cyc(2);
         chk(tx_data, 27'(f != 3), "tx bit held");
      end
      wr(pscr_pkg::ADDR_PACKET_LENGTH, 8'h20);
      wr(pscr_pkg::ADDR_PACKET_FORMAT, 8'h44);
      cyc(2);
      chk(pkt_len_limit, 8'h20, "fixed length");
      wr(pscr_pkg::ADDR_PACKET_LENGTH, 8'h21);
      cyc(2);
      chk(pkt_len_limit, 8'h21, "fixed length update");
      chk(pkt_len_infinite, 0, "not infinite");
      wr(pscr_pkg::ADDR_PACKET_FORMAT, 8'h45);
      rx_pulse(1'b1, 8'h10);
      chk(pkt_len_limit, 8'h10, "variable length");
      rx_pulse(1'b1, 8'h21);
      chk(pkt_len_error, 0, "length at max");
      rx_pulse(1'b1, 8'h22);
      chk(pkt_len_error, 1, "length over max");
      wr(pscr_pkg::ADDR_PACKET_FORMAT, 8'h46);
      cyc(2);
      chk(pkt_len_infinite, 1, "infinite length");
      wr(pscr_pkg::ADDR_NODE_FILTER, 8'h5a);
      for (int m = 0; m < 4; m++) begin
         wr(pscr_pkg::ADDR_PACKET_FILTER, 8'(4 + m));
         for (int k = 0; k < 4; k++) begin
            rx_pulse(1'b0, ABYTES[k]);
            chk(addr_done, 1, "addr done");
            chk(addr_accept, 27'(m == 0 || ABYTES[k] == 8'h5a || (m >= 2 && ABYTES[k] == 8'h00) ||
               (m == 3 && ABYTES[k] == 8'hff)), "addr accept");
         end
      end
      wr(pscr_pkg::ADDR_CARRIER_HIGH, 8'hff);
      wr(pscr_pkg::ADDR_CARRIER_MIDDLE, 8'h12);
      wr(pscr_pkg::ADDR_CARRIER_LOW, 8'h34);
      wr(pscr_pkg::ADDR_CHANNEL_INDEX, 8'hff);
      wr(pscr_pkg::ADDR_SYNTH_OFFSET, 8'h80);
      wr(pscr_pkg::ADDR_IF_CARRIER_WORD, 8'hff);
      // channel ff and offset 80 catch signed/unsigned mix-ups
      for (int r = 0; r < 2; r++) begin
         rx_mode = r[0];
         cyc(3);
         exp_synth = 'h3f1234 + 255 * 256 - 128 * 4 - r * 31 * 64;
         chk(synth_word, exp_synth[26:0], "synth word");
      end
      chk(intermediate_carrier_word_word, 5'h1f, "if word");
      summarize();
   end
endmodule
